// *** hw/flash_program_erase_ctrl.sv ***
// Contract
// - high voltage may be set only with program or erase set and sequence done; the code keeps it on when both selects are cleared with the bit still 1
// - high voltage bit on drives pump and array voltage; off removes them
// - mass bit: 1 erases whole array, 0 erases one page
// - erase and program select are never both 1, nor set together
// - program select 1 prepares programming; 0 deselects it
// - page erase clears one 128-byte page to all ones
// - programming works on 64-byte aligned rows
// - all writes of one programming cycle must hit one row, else fail
// - program select then protect read makes array writes latch
//
// Local design decisions: the address map and the Wishbone register port.
`timescale 1ns/1ns
module flash_program_erase_ctrl (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // wishbone slave
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [flash_pkg::ADDR_W-1:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [flash_pkg::DATA_W-1:0] wbDatIn,
  output logic [flash_pkg::DATA_W-1:0] wbDatOut,
  output logic wbAck,
  // array macro
  output flash_pkg::array_cmd_t arrayCmd,
  output logic rowFail
);

  flash_pkg::array_cmd_t cmd_reg, cmd_next;
  flash_pkg::seq_t seq_reg, seq_next;
  logic [7:0] prot_reg, prot_next;
  logic ack_reg, ack_next;
  logic [flash_pkg::DATA_W-1:0] rdat_reg, rdat_next;
  logic acc, isArray, trkClear, trkStb, haveRow;
  logic newProg, newErase, nextProg, nextErase;

  // request taken on the first cycle it is seen; ack follows one cycle later
  assign acc = wbCyc && wbStb && !ack_reg;
  assign isArray = wbAdr[flash_pkg::ARRAY_SEL_BIT];

  always_comb begin
    cmd_next = cmd_reg;
    cmd_next.latchStb = 1'b0;
    seq_next = seq_reg;
    prot_next = prot_reg;
    ack_next = acc;
    rdat_next = flash_pkg::IDLE_RDATA;
    trkStb = 1'b0;
    newProg = wbDatIn[flash_pkg::PROG_BIT];
    newErase = wbDatIn[flash_pkg::ERASE_BIT];
    nextProg = cmd_reg.progSel;
    nextErase = cmd_reg.eraseSel;
    if (acc && isArray) begin
      // array reads are served by the macro, not here
      if (wbWe && wbSel[0] && !cmd_reg.hvOn) begin
        if (cmd_reg.eraseSel && seq_reg == flash_pkg::SEQ_PROT) begin
          cmd_next.addr = wbAdr[flash_pkg::ARRAY_W-1:0]
            & flash_pkg::PAGE_MASK;
          seq_next = flash_pkg::SEQ_LATCHED;
        end else if (cmd_reg.progSel
            && (seq_reg == flash_pkg::SEQ_PROT
              || seq_reg == flash_pkg::SEQ_LATCHED)) begin
          cmd_next.addr = wbAdr[flash_pkg::ARRAY_W-1:0];
          cmd_next.data = wbDatIn[7:0];
          cmd_next.latchStb = 1'b1;
          trkStb = 1'b1;
          seq_next = flash_pkg::SEQ_LATCHED;
        end
      end
    end else if (acc) begin
      case (wbAdr)
        flash_pkg::CTRL_OFS: begin
          rdat_next = ctrlRead(cmd_reg);
          if (wbWe && wbSel[0]) begin
            // ignoring the pair keeps both modes out of one cycle
            if (!(newProg && newErase)) begin
              nextProg = newProg;
              nextErase = newErase;
            end
            cmd_next.progSel = nextProg;
            cmd_next.eraseSel = nextErase;
            cmd_next.massSel = wbDatIn[flash_pkg::MASS_BIT];
            if (!nextProg && !nextErase) begin
              seq_next = flash_pkg::SEQ_IDLE;
            end else if (nextProg != cmd_reg.progSel
                || nextErase != cmd_reg.eraseSel) begin
              seq_next = flash_pkg::SEQ_ARMED;
            end
            if (!wbDatIn[flash_pkg::HV_BIT]) begin
              cmd_next.hvOn = 1'b0;
            end else if ((nextProg || nextErase)
                && seq_next == flash_pkg::SEQ_LATCHED) begin
              cmd_next.hvOn = 1'b1;
            end
          end
        end
        flash_pkg::PROT_OFS: begin
          rdat_next = {24'h00_0000, prot_reg};
          if (wbWe && wbSel[0]) begin
            prot_next = wbDatIn[7:0];
          end else if (!wbWe && seq_reg == flash_pkg::SEQ_ARMED) begin
            seq_next = flash_pkg::SEQ_PROT;
          end
        end
        flash_pkg::STAT_OFS: begin
          rdat_next = {26'h000_0000, rowFail, haveRow, seq_reg};
        end
        default: begin
          rdat_next = flash_pkg::IDLE_RDATA;
        end
      endcase
    end
  end

  // tracker restarts whenever a new operation is armed
  assign trkClear = seq_next == flash_pkg::SEQ_ARMED;

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      cmd_reg <= '0;
      seq_reg <= flash_pkg::SEQ_IDLE;
      prot_reg <= flash_pkg::PROT_RESET;
      ack_reg <= 1'b0;
      rdat_reg <= flash_pkg::IDLE_RDATA;
    end else begin
      cmd_reg <= cmd_next;
      seq_reg <= seq_next;
      prot_reg <= prot_next;
      ack_reg <= ack_next;
      rdat_reg <= rdat_next;
    end
  end

  function automatic logic [31:0] ctrlRead(flash_pkg::array_cmd_t c);
    logic [31:0] r;
    r = flash_pkg::IDLE_RDATA;
    r[flash_pkg::PROG_BIT] = c.progSel;
    r[flash_pkg::ERASE_BIT] = c.eraseSel;
    r[flash_pkg::MASS_BIT] = c.massSel;
    r[flash_pkg::HV_BIT] = c.hvOn;
    return r;
  endfunction : ctrlRead

  flash_row_tracker #(
    .ADDR_W(flash_pkg::ARRAY_W),
    .ROW_LSB(flash_pkg::ROW_LSB)
  ) rowTrack (
    .mclk(mclk),
    .rstn(rstn),
    .clear(trkClear),
    .wrStb(trkStb),
    .wrAddr(wbAdr[flash_pkg::ARRAY_W-1:0]),
    .haveRow(haveRow),
    .rowFail(rowFail)
  );

  assign arrayCmd = cmd_reg;
  assign wbAck = ack_reg;
  assign wbDatOut = rdat_reg;

  // checks on the sequencer

  hv_gate_a:
    assert property (@(posedge mclk) disable iff (!rstn)
      $rose(arrayCmd.hvOn) |->
        (arrayCmd.progSel || arrayCmd.eraseSel)
        && $past(seq_reg) == flash_pkg::SEQ_LATCHED)
    else $error("high voltage rose without a completed sequence");

  hv_clear_a:
    assert property (@(posedge mclk) disable iff (!rstn)
      (acc && !isArray && wbWe && wbSel[0]
        && wbAdr == flash_pkg::CTRL_OFS && !wbDatIn[flash_pkg::HV_BIT])
        |=> !arrayCmd.hvOn)
    else $error("clearing high voltage did not remove it");

  mode_excl_a:
    assert property (@(posedge mclk) disable iff (!rstn)
      !(arrayCmd.progSel && arrayCmd.eraseSel))
    else $error("program and erase selected together");

  both_hold_a:
    assert property (@(posedge mclk) disable iff (!rstn)
      (acc && !isArray && wbWe && wbSel[0] && wbAdr == flash_pkg::CTRL_OFS
        && newProg && newErase)
        |=> $stable(arrayCmd.progSel) && $stable(arrayCmd.eraseSel))
    else $error("double select write changed a select bit");

  mass_take_a:
    assert property (@(posedge mclk) disable iff (!rstn)
      (acc && !isArray && wbWe && wbSel[0] && wbAdr == flash_pkg::CTRL_OFS)
        |=> arrayCmd.massSel == $past(wbDatIn[flash_pkg::MASS_BIT]))
    else $error("mass select did not follow the write");

  prog_take_a:
    assert property (@(posedge mclk) disable iff (!rstn)
      (acc && !isArray && wbWe && wbSel[0] && wbAdr == flash_pkg::CTRL_OFS
        && newProg && !newErase) |=> arrayCmd.progSel ##1 wbAck == 1'b0)
    else $error("program select write not taken");

  page_latch_a:
    assert property (@(posedge mclk) disable iff (!rstn)
      (acc && isArray && wbWe && wbSel[0] && !arrayCmd.hvOn
        && arrayCmd.eraseSel && seq_reg == flash_pkg::SEQ_PROT)
        |=> seq_reg == flash_pkg::SEQ_LATCHED
          && (arrayCmd.addr & ~flash_pkg::PAGE_MASK) == 15'h0000)
    else $error("page address not latched page aligned");

  data_latch_a:
    assert property (@(posedge mclk) disable iff (!rstn)
      (acc && isArray && wbWe && wbSel[0] && !arrayCmd.hvOn
        && arrayCmd.progSel && seq_reg != flash_pkg::SEQ_IDLE
        && seq_reg != flash_pkg::SEQ_ARMED)
        |=> arrayCmd.latchStb && arrayCmd.data == $past(wbDatIn[7:0])
        ##1 !arrayCmd.latchStb)
    else $error("program write not latched as a single pulse");

  prot_arm_a:
    assert property (@(posedge mclk) disable iff (!rstn)
      (acc && !isArray && !wbWe && wbAdr == flash_pkg::PROT_OFS
        && seq_reg == flash_pkg::SEQ_ARMED)
        |=> seq_reg == flash_pkg::SEQ_PROT)
    else $error("protect read did not open the sequence");

  ack_pulse_a:
    assert property (@(posedge mclk) disable iff (!rstn)
      (wbCyc && wbStb && !wbAck) |=> wbAck ##1 !wbAck)
    else $error("bus answer not a one-cycle pulse");

endmodule : flash_program_erase_ctrl

// *** shared/flash_pkg.sv ***
package flash_pkg;

  // bus geometry
  localparam int ADDR_W = 16;
  localparam int DATA_W = 32;
  localparam int ARRAY_W = 15;
  localparam int ARRAY_SEL_BIT = 15;

  // register byte addresses
  localparam logic [15:0] CTRL_OFS = 16'h0000;
  localparam logic [15:0] PROT_OFS = 16'h0004;
  localparam logic [15:0] STAT_OFS = 16'h0008;

  // control register fields
  localparam int PROG_BIT = 0;
  localparam int ERASE_BIT = 1;
  localparam int MASS_BIT = 2;
  localparam int HV_BIT = 3;

  // reset values
  localparam logic [7:0] PROT_RESET = 8'h00;
  localparam logic [31:0] IDLE_RDATA = 32'h0000_0000;

  // array geometry: 64-byte rows, 128-byte pages
  localparam int ROW_LSB = 6;
  localparam int PAGE_LSB = 7;
  localparam logic [14:0] PAGE_MASK = 15'h7F80;

  typedef enum logic [3:0] {
    SEQ_IDLE = 4'h1,
    SEQ_ARMED = 4'h2,
    SEQ_PROT = 4'h4,
    SEQ_LATCHED = 4'h8
  } seq_t;

  // everything the array macro sees
  typedef struct packed {
    logic hvOn;
    logic massSel;
    logic eraseSel;
    logic progSel;
    logic [14:0] addr;
    logic [7:0] data;
    logic latchStb;
  } array_cmd_t;

endpackage : flash_pkg

// *** hw/flash_row_tracker.sv ***
`timescale 1ns/1ns
module flash_row_tracker #(
  parameter int ADDR_W = flash_pkg::ARRAY_W,
  parameter int ROW_LSB = flash_pkg::ROW_LSB
) (
  // clock and reset
  input wire logic mclk,
  input wire logic rstn,
  // latched writes
  input wire logic clear,
  input wire logic wrStb,
  input wire logic [ADDR_W-1:0] wrAddr,
  // result
  output logic haveRow,
  output logic rowFail
);

  logic [ADDR_W-ROW_LSB-1:0] row_reg, row_next;
  logic haveRow_reg, haveRow_next;
  logic fail_reg, fail_next;

  always_comb begin
    row_next = row_reg;
    haveRow_next = haveRow_reg;
    fail_next = fail_reg;
    if (clear) begin
      haveRow_next = 1'b0;
      fail_next = 1'b0;
    end else if (wrStb) begin
      if (!haveRow_reg) begin
        row_next = wrAddr[ADDR_W-1:ROW_LSB];
        haveRow_next = 1'b1;
      end else if (wrAddr[ADDR_W-1:ROW_LSB] != row_reg) begin
        fail_next = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      row_reg <= '0;
      haveRow_reg <= 1'b0;
      fail_reg <= 1'b0;
    end else begin
      row_reg <= row_next;
      haveRow_reg <= haveRow_next;
      fail_reg <= fail_next;
    end
  end

  assign haveRow = haveRow_reg;
  assign rowFail = fail_reg;

  row_cross_a:
    assert property (@(posedge mclk) disable iff (!rstn)
      (!clear && wrStb && haveRow_reg
        && wrAddr[ADDR_W-1:ROW_LSB] != row_reg) |=> rowFail)
    else $error("write outside the open row did not flag failure");

  row_same_a:
    assert property (@(posedge mclk) disable iff (!rstn)
      (!clear && !fail_reg && wrStb && haveRow_reg
        && wrAddr[ADDR_W-1:ROW_LSB] == row_reg) |=> !rowFail)
    else $error("write inside the open row flagged failure");

endmodule : flash_row_tracker

// *** sim/tb_top.sv ***
`timescale 1ns/1ns
module tb_top;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [flash_pkg::ADDR_W-1:0] wbAdr = 16'h0000;
  logic [3:0] wbSel = 4'h0;
  logic [flash_pkg::DATA_W-1:0] wbDatIn = 32'h0000_0000;
  logic [flash_pkg::DATA_W-1:0] wbDatOut;
  logic wbAck;
  flash_pkg::array_cmd_t arrayCmd;
  logic rowFail;
  int fail_count = 0;
  int checked = 0;
  int cycles = 0;
  logic [31:0] rd;
  flash_pkg::array_cmd_t cmd;
  logic [14:0] a;
  logic [7:0] d;

  flash_program_erase_ctrl dut_u (
    .mclk(mclk),
    .rstn(rstn),
    .wbCyc(wbCyc),
    .wbStb(wbStb),
    .wbWe(wbWe),
    .wbAdr(wbAdr),
    .wbSel(wbSel),
    .wbDatIn(wbDatIn),
    .wbDatOut(wbDatOut),
    .wbAck(wbAck),
    .arrayCmd(arrayCmd),
    .rowFail(rowFail)
  );

  initial begin
    forever #5 mclk = ~mclk;
  end

  // whole run is a little over a hundred cycles; generous ceiling
  always @(posedge mclk) begin
    cycles++;
    if (cycles == 5000) begin
      fail_count++;
      $display("[ERR] %0t run timed out", $time);
      summarize();
    end
  end

  task summarize;
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : summarize

  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask : chk

  // leading edge keeps cyc low one cycle between transfers
  task xfer(input logic we, input logic [15:0] adr, input logic [31:0] dat,
            input logic [3:0] sel);
    @(posedge mclk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbSel <= sel;
    wbDatIn <= dat;
    // a lost ack ends in the run timeout, not here
    do begin
      @(posedge mclk);
    end while (wbAck !== 1'b1);
    rd = wbDatOut;
    cmd = arrayCmd;
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : xfer

  task ctl(input logic [3:0] v);
    xfer(1'b1, flash_pkg::CTRL_OFS, {28'h0, v}, 4'hF);
  endtask : ctl

  function automatic logic [31:0] sel4(flash_pkg::array_cmd_t c);
    return {28'h0, c.hvOn, c.massSel, c.eraseSel, c.progSel};
  endfunction : sel4

  function automatic logic [14:0] pageBase(logic [14:0] x);
    return x & flash_pkg::PAGE_MASK;
  endfunction : pageBase

  initial begin
    void'($urandom(32'hF70465C1));
    repeat (4) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    chk({4'h0, arrayCmd}, 32'h0, "cmd after reset");
    xfer(1'b0, flash_pkg::PROT_OFS, 32'h0, 4'hF);
    chk(rd, {24'h0, flash_pkg::PROT_RESET}, "protect reset");
    xfer(1'b0, flash_pkg::STAT_OFS, 32'h0, 4'hF);
    chk(rd, {28'h0, flash_pkg::SEQ_IDLE}, "status idle");
    xfer(1'b0, 16'h0010, 32'h0, 4'hF);
    chk(rd, 32'h0, "unmapped read");
    d = 8'($urandom);
    xfer(1'b1, flash_pkg::PROT_OFS, {24'h0, d}, 4'hE);
    xfer(1'b0, flash_pkg::PROT_OFS, 32'h0, 4'hF);
    chk(rd, 32'h0, "lane0 off write");
    xfer(1'b1, flash_pkg::PROT_OFS, {24'h0, d}, 4'hF);
    xfer(1'b0, flash_pkg::PROT_OFS, 32'h0, 4'hF);
    chk(rd, {24'h0, d}, "protect rw");
    ctl(4'h8);
    chk(sel4(cmd), 32'h0, "hv from idle");
    ctl(4'h3);
    chk(sel4(cmd), 32'h0, "both selects");
    ctl(4'h2);
    ctl(4'h3);
    chk(sel4(cmd), 32'h2, "both from erase");
    ctl(4'hA);
    chk(sel4(cmd), 32'h2, "hv before sequence");
    // page erase, then a second page write that must not move the address
    xfer(1'b0, flash_pkg::PROT_OFS, 32'h0, 4'hF);
    a = 15'($urandom);
    xfer(1'b1, {1'b1, a}, $urandom, 4'hF);
    chk({17'h0, cmd.addr}, {17'h0, pageBase(a)}, "page base");
    chk(sel4(cmd), 32'h2, "page scope");
    xfer(1'b1, {1'b1, a ^ 15'h0080}, $urandom, 4'hF);
    chk({17'h0, cmd.addr}, {17'h0, pageBase(a)}, "second page");
    xfer(1'b0, flash_pkg::STAT_OFS, 32'h0, 4'hF);
    chk({28'h0, rd[3:0]}, {28'h0, flash_pkg::SEQ_LATCHED}, "between steps");
    ctl(4'hA);
    chk(sel4(cmd), 32'hA, "hv on erase");
    ctl(4'h8);
    chk(sel4(cmd), 32'h8, "erase off");
    ctl(4'h0);
    chk(sel4(cmd), 32'h0, "hv off");
    ctl(4'h6);
    chk(sel4(cmd), 32'h6, "mass scope");
    ctl(4'h0);
    // program one row, corners first, then stray into the other row of the page
    ctl(4'h1);
    chk(sel4(cmd), 32'h1, "program select");
    xfer(1'b1, {1'b1, a}, 32'h0, 4'hF);
    chk({31'h0, cmd.latchStb}, 32'h0, "latch before protect");
    xfer(1'b0, flash_pkg::PROT_OFS, 32'h0, 4'hF);
    a = pageBase(a) | {8'h00, 1'($urandom), 6'h00};
    for (int i = 0; i < 6; i++) begin
      a[5:0] = (i == 0) ? 6'h00 : (i == 1) ? 6'h3F : 6'($urandom);
      d = 8'($urandom);
      xfer(1'b1, {1'b1, a}, {24'h0, d}, 4'hF);
      chk({17'h0, cmd.addr}, {17'h0, a}, "prog addr");
      chk({24'h0, cmd.data}, {24'h0, d}, "prog data");
      chk({31'h0, cmd.latchStb}, 32'h1, "latch pulse");
    end
    repeat (2) @(posedge mclk);
    chk({31'h0, rowFail}, 32'h0, "one row");
    xfer(1'b0, flash_pkg::STAT_OFS, 32'h0, 4'hF);
    chk({28'h0, rd[3:0]}, {28'h0, flash_pkg::SEQ_LATCHED}, "latched");
    chk({31'h0, cmd.latchStb}, 32'h0, "latch ends");
    xfer(1'b1, {1'b1, a ^ 15'h0040}, $urandom, 4'hF);
    repeat (2) @(posedge mclk);
    chk({31'h0, rowFail}, 32'h1, "row span");
    ctl(4'h9);
    chk(sel4(cmd), 32'h9, "hv on program");
    ctl(4'h0);
    chk(sel4(cmd), 32'h0, "deselect");
    // failure stays visible until a new operation or a reset
    chk({31'h0, rowFail}, 32'h1, "fail kept");
    rstn <= 1'b0;
    repeat (2) @(posedge mclk);
    rstn <= 1'b1;
    @(posedge mclk);
    chk({4'h0, arrayCmd}, 32'h0, "cmd after second reset");
    chk({31'h0, rowFail}, 32'h0, "fail after reset");
    xfer(1'b0, flash_pkg::STAT_OFS, 32'h0, 4'hF);
    chk(rd, {28'h0, flash_pkg::SEQ_IDLE}, "status after reset");
    summarize();
  end
endmodule : tb_top
